// File: rsf_params.svh
// offsets, field positions, reset values and timing counts of the radio register bank
`ifndef RSF_PARAMS_SVH
`define RSF_PARAMS_SVH

// register indices on apb (byte address divided by four)
`define RSF_IDX_STATUS 8'h01
`define RSF_IDX_STATE 8'h02
`define RSF_IDX_SADDR_LO 8'h20
`define RSF_IDX_SADDR_HI 8'h21
`define RSF_IDX_NETID_LO 8'h22
`define RSF_IDX_NETID_HI 8'h23
`define RSF_IDX_RETRY 8'h2c
`define RSF_IDX_SEED_LO 8'h2d
`define RSF_IDX_SEED_HI 8'h2e
`define RSF_IDX_IRQ_STAT 8'h30
`define RSF_IDX_IRQ_MASK 8'h31

// reset values
`define RSF_RST_SEED_LO 8'hea
`define RSF_RST_RETRY 8'h00
`define RSF_RST_SEED_HI 8'h00

// command codes and status codes
`define RSF_CMD_NOP 5'h00
`define RSF_CMD_TX_START 5'h02
`define RSF_CMD_FORCED_OFF 5'h03
`define RSF_CMD_RX_LISTEN 5'h06
`define RSF_CMD_IDLE 5'h08
`define RSF_CMD_SYNTH_ON 5'h09
`define RSF_CMD_AACK 5'h16
`define RSF_CMD_ARET 5'h19
`define RSF_ST_BUSY_TX 5'h02
`define RSF_ST_BUSY 5'h1f

// transaction result codes
`define RSF_RES_SUCCESS 3'h0
`define RSF_RES_PENDING 3'h1
`define RSF_RES_CA_FAIL 3'h3
`define RSF_RES_NO_ACK 3'h5
`define RSF_RES_INVALID 3'h7

// interrupt status bits
`define RSF_IRQ_FRAME_END 0
`define RSF_IRQ_TX_START 1

// timing
`define RSF_CLK_MHZ 100
`define RSF_SYMBOL_US 16
`define RSF_SYMBOL_CYC (`RSF_SYMBOL_US * `RSF_CLK_MHZ)
`define RSF_SETTLE_CYC 16

`endif

// File: rsf_pkg.sv
// types of the radio state and filter register bank
package rsf_pkg;
    typedef enum logic [1:0] {
        RSF_IDLE,
        RSF_SETTLE,
        RSF_TX_WAIT
    } rsf_fsm_t;
endpackage

// File: rsf_regs.sv
// radio state and filter register bank with apb slave
//
// Function
// RULE1: command field write starts state transition
// RULE2: eight command codes, others reserved
// RULE3: transmit begins one symbol after command
// RULE4: result field reports transaction outcome codes
// RULE5: controller confirms transition via status read
// RULE6: frame retry limit in bits 7..4
// RULE7: channel access retry count in bits 3..1
// RULE8: channel access retries accepted up to 7
// RULE9: eleven-bit backoff seed over two registers
// RULE10: min backoff exponent; zero means no delay
// RULE11: pending flag sets ack frame-pending for requests
// RULE12: controller updates pending flag within 352 us
// RULE13: coordinator flag gates source-only frame filter
// RULE14: short address at 0x20/0x21, reset zero
// RULE15: network id at 0x22/0x23, reset zero
// RULE16: busy code 0x1f while transition runs
// RULE17: channel access failure aborts, raises frame end
// RULE18: reserved bits zero, reserved commands ignored
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "rsf_params.svh"

module rsf_regs
    import rsf_pkg::*;
#(
    parameter int SETTLE_CYC = `RSF_SETTLE_CYC,
    parameter int SYMBOL_CYC = `RSF_SYMBOL_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // radio engine side, same clock
    input wire logic txn_done,
    input wire logic [2:0] txn_result,
    input wire logic ca_exhausted,
    input wire logic [4:0] engine_state,
    input wire logic ack_for_data_req,
    input wire logic frame_src_only,
    input wire logic [15:0] frame_src_netid,
    // configuration and control outputs
    output logic [4:0] state_command,
    output logic cmd_strobe,
    output logic tx_on_air,
    output logic [3:0] frame_retry_limit,
    output logic [2:0] channel_access_retry_limit,
    output logic [10:0] backoff_seed,
    output logic [1:0] min_backoff_exponent,
    output logic cca_immediate,
    output logic ack_frame_pending,
    output logic coordinator_flag,
    output logic src_filter_pass,
    output logic [15:0] short_address,
    output logic [15:0] network_id,
    // interrupt
    output logic irq
);

    // ========================================
    // state
    typedef struct packed {
        rsf_fsm_t fsm;
        logic [31:0] cnt;
        logic [4:0] cmd;
        logic [4:0] target;
        logic [2:0] result;
        logic [7:0] retry;
        logic [7:0] seed_lo;
        logic [7:0] seed_hi;
        logic [15:0] saddr;
        logic [15:0] netid;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic strobe;
        logic tx_go;
        logic [31:0] rdata;
        logic rd_ok;
    } rsf_state_t;

    rsf_state_t st_r;
    rsf_state_t st_nxt;

    // ========================================
    // bus decode
    logic [7:0] idx;
    logic wr_acc;
    logic rd_acc;
    logic mapped;
    logic [4:0] cur_code;

    assign idx = paddr[9:2];
    assign wr_acc = psel && penable && pwrite && pstrb[0];
    assign rd_acc = psel && penable && !pwrite;

    always_comb begin
        unique case (idx)
            `RSF_IDX_STATUS,
            `RSF_IDX_STATE,
            `RSF_IDX_SADDR_LO,
            `RSF_IDX_SADDR_HI,
            `RSF_IDX_NETID_LO,
            `RSF_IDX_NETID_HI,
            `RSF_IDX_RETRY,
            `RSF_IDX_SEED_LO,
            `RSF_IDX_SEED_HI,
            `RSF_IDX_IRQ_STAT,
            `RSF_IDX_IRQ_MASK: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // busy code overrides engine report while a transition runs
    assign cur_code = (st_r.fsm != RSF_IDLE) ? `RSF_ST_BUSY
                                             : engine_state; // [RULE16]

    function automatic logic legal_cmd(input logic [4:0] c);
        logic ok;
        ok = 1'b0;
        unique case (c)
            `RSF_CMD_TX_START, `RSF_CMD_FORCED_OFF, `RSF_CMD_RX_LISTEN,
            `RSF_CMD_IDLE, `RSF_CMD_SYNTH_ON, `RSF_CMD_AACK,
            `RSF_CMD_ARET: ok = 1'b1; // [RULE2]
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction

    // ========================================
    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.strobe = 1'b0;
        st_nxt.tx_go = 1'b0;
        st_nxt.rdata = 32'h0000_0000;
        st_nxt.rd_ok = 1'b0;

        // transition sequencer
        unique case (st_r.fsm)
            RSF_IDLE: begin
            end
            RSF_SETTLE: begin
                if (st_r.cnt == 32'h0000_0000) begin
                    st_nxt.fsm = RSF_IDLE;
                end else begin
                    st_nxt.cnt = st_r.cnt - 32'h0000_0001;
                end
            end
            RSF_TX_WAIT: begin
                if (st_r.cnt == 32'h0000_0000) begin
                    st_nxt.fsm = RSF_IDLE;
                    st_nxt.tx_go = 1'b1; // [RULE3]
                end else begin
                    st_nxt.cnt = st_r.cnt - 32'h0000_0001;
                end
            end
        endcase

        // engine events update result; channel access failure wins over a reported result
        if (ca_exhausted) begin
            st_nxt.result = `RSF_RES_CA_FAIL; // [RULE17]
        end else if (txn_done) begin
            st_nxt.result = txn_result; // [RULE4]
        end

        // register writes
        if (wr_acc) begin
            unique case (idx)
                `RSF_IDX_STATE: begin
                    if (legal_cmd(pwdata[4:0])) begin
                        st_nxt.cmd = pwdata[4:0];
                        st_nxt.strobe = 1'b1; // [RULE1]
                        st_nxt.cnt = 32'(SETTLE_CYC - 1);
                        st_nxt.fsm = RSF_SETTLE;
                        if (pwdata[4:0] == `RSF_CMD_TX_START) begin
                            st_nxt.cnt = 32'(SYMBOL_CYC - 1); // [RULE3]
                            st_nxt.fsm = RSF_TX_WAIT;
                        end
                    end else if (pwdata[4:0] == `RSF_CMD_NOP) begin
                        st_nxt.cmd = `RSF_CMD_NOP;
                    end // reserved codes leave all state alone [RULE18]
                end
                `RSF_IDX_SADDR_LO: begin
                    st_nxt.saddr[7:0] = pwdata[7:0]; // [RULE14]
                end
                `RSF_IDX_SADDR_HI: begin
                    st_nxt.saddr[15:8] = pwdata[7:0]; // [RULE14]
                end
                `RSF_IDX_NETID_LO: begin
                    st_nxt.netid[7:0] = pwdata[7:0]; // [RULE15]
                end
                `RSF_IDX_NETID_HI: begin
                    st_nxt.netid[15:8] = pwdata[7:0]; // [RULE15]
                end
                `RSF_IDX_RETRY: begin
                    st_nxt.retry = {pwdata[7:1], 1'b0}; // [RULE8]
                end
                `RSF_IDX_SEED_LO: begin
                    st_nxt.seed_lo = pwdata[7:0]; // [RULE9]
                end
                `RSF_IDX_SEED_HI: begin
                    st_nxt.seed_hi = {pwdata[7:5], 1'b0,
                                      pwdata[3:0]}; // [RULE18]
                end
                `RSF_IDX_IRQ_STAT: begin
                    st_nxt.irq_stat = st_r.irq_stat & ~pwdata[1:0];
                end
                `RSF_IDX_IRQ_MASK: begin
                    st_nxt.irq_mask = pwdata[1:0];
                end
                default: begin
                end
            endcase
        end

        // set wins over write-one-to-clear
        if (txn_done || ca_exhausted) begin
            st_nxt.irq_stat[`RSF_IRQ_FRAME_END] = 1'b1; // [RULE17]
        end
        if (st_nxt.tx_go) begin
            st_nxt.irq_stat[`RSF_IRQ_TX_START] = 1'b1;
        end

        // read data captured in the first access cycle, shown in the
        // second, where pready rises; keeps prdata a flip-flop output
        if (rd_acc && !st_r.rd_ok) begin
            st_nxt.rd_ok = 1'b1;
            unique case (idx)
                `RSF_IDX_STATUS: begin
                    st_nxt.rdata = {27'h0, cur_code}; // [RULE5]
                end
                `RSF_IDX_STATE: begin
                    st_nxt.rdata = {24'h0, st_r.result, st_r.cmd};
                end
                `RSF_IDX_SADDR_LO: begin
                    st_nxt.rdata = {24'h0, st_r.saddr[7:0]};
                end
                `RSF_IDX_SADDR_HI: begin
                    st_nxt.rdata = {24'h0, st_r.saddr[15:8]};
                end
                `RSF_IDX_NETID_LO: begin
                    st_nxt.rdata = {24'h0, st_r.netid[7:0]};
                end
                `RSF_IDX_NETID_HI: begin
                    st_nxt.rdata = {24'h0, st_r.netid[15:8]};
                end
                `RSF_IDX_RETRY: begin
                    st_nxt.rdata = {24'h0, st_r.retry};
                end
                `RSF_IDX_SEED_LO: begin
                    st_nxt.rdata = {24'h0, st_r.seed_lo};
                end
                `RSF_IDX_SEED_HI: begin
                    st_nxt.rdata = {24'h0, st_r.seed_hi};
                end
                `RSF_IDX_IRQ_STAT: begin
                    st_nxt.rdata = {30'h0, st_r.irq_stat};
                end
                `RSF_IDX_IRQ_MASK: begin
                    st_nxt.rdata = {30'h0, st_r.irq_mask};
                end
                default: begin
                    st_nxt.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // ========================================
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '{
                fsm: RSF_IDLE,
                cnt: 32'h0,
                cmd: `RSF_CMD_NOP,
                target: 5'h00,
                result: `RSF_RES_SUCCESS,
                retry: `RSF_RST_RETRY,
                seed_lo: `RSF_RST_SEED_LO,
                seed_hi: `RSF_RST_SEED_HI,
                saddr: 16'h0000,
                netid: 16'h0000,
                irq_stat: 2'h0,
                irq_mask: 2'h0,
                strobe: 1'b0,
                tx_go: 1'b0,
                rdata: 32'h0,
                rd_ok: 1'b0
            };
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // ========================================
    // outputs
    // reads take one wait state, writes none
    assign prdata = st_r.rdata;
    assign pready = !(psel && penable && !pwrite) || st_r.rd_ok;
    assign pslverr = psel && penable && !mapped;

    assign state_command = st_r.cmd;
    assign cmd_strobe = st_r.strobe; // [RULE1]
    assign tx_on_air = st_r.tx_go; // [RULE3]
    assign frame_retry_limit = st_r.retry[7:4]; // [RULE6]
    assign channel_access_retry_limit = st_r.retry[3:1]; // [RULE7]
    assign backoff_seed = {st_r.seed_hi[2:0], st_r.seed_lo}; // [RULE9]
    assign min_backoff_exponent = st_r.seed_hi[7:6]; // [RULE10]
    assign cca_immediate = (st_r.seed_hi[7:6] == 2'b00); // [RULE10]
    // sampled live so a late update of the flag still lands in the ack
    assign ack_frame_pending = (st_r.cmd == `RSF_CMD_AACK) && st_r.seed_hi[5]
                               && ack_for_data_req; // [RULE11]
    assign coordinator_flag = st_r.seed_hi[3];
    assign src_filter_pass = !(st_r.seed_hi[3] && frame_src_only)
                             || (frame_src_netid == st_r.netid); // [RULE13]
    assign short_address = st_r.saddr;
    assign network_id = st_r.netid;
    assign irq = |(st_r.irq_stat & st_r.irq_mask);

endmodule
`default_nettype wire

// File: rsf_mcu.sv
// apb master model standing in for the external controller
`timescale 1ns/100ps
`default_nettype none
module rsf_mcu (
    // clock
    input wire logic pclk,
    // apb master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic err = 1'b0;
    initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    // one transfer, held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] ix,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, ix, 2'b00};
        pwdata <= {24'h0, d};
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        // read data and error taken at the very edge pready is seen
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released lines flip, so stale values never look valid
        paddr <= ~paddr;
        pwdata <= ~pwdata;
    endtask
    // command, then status read to confirm the transition
    task automatic cmd(input logic [4:0] c, output logic [4:0] st);
        logic [7:0] q;
        xfer(1'b1, 8'h02, {3'h0, c}, q);
        xfer(1'b0, 8'h01, 8'h00, q);
        st = q[4:0];
    endtask
endmodule
`default_nettype wire

// File: rsf_checker.sv
// assertions on the ports of the radio register bank
`timescale 1ns/100ps
`default_nettype none
module rsf_checker #(
    parameter int SYMBOL_CYC = 1600
) (
    // clock, reset, apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pslverr,
    // command and configuration
    input wire logic [4:0] state_command,
    input wire logic cmd_strobe,
    input wire logic tx_on_air,
    input wire logic [3:0] frame_retry_limit,
    input wire logic [2:0] channel_access_retry_limit,
    input wire logic [1:0] min_backoff_exponent,
    input wire logic cca_immediate,
    // receive side
    input wire logic ack_for_data_req,
    input wire logic ack_frame_pending,
    input wire logic frame_src_only,
    input wire logic [15:0] frame_src_netid,
    input wire logic coordinator_flag,
    input wire logic src_filter_pass,
    input wire logic [15:0] network_id
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic wr = psel && penable && pwrite && pstrb[0];
    wire logic [7:0] ix = paddr[9:2];
    wire logic ok = pwdata[4:0] inside {5'h02, 5'h03, 5'h06, 5'h08, 5'h09,
                                        5'h16, 5'h19};
    // cycles since the last accepted command; a new one restarts it
    int unsigned age_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) age_r <= 0;
        else if (cmd_strobe) age_r <= 0;
        else age_r <= age_r + 1;
    end
    a_unmapped_err:
        assert property (psel && penable && paddr == 12'h100 |-> pslverr)
        else $error("unmapped access not flagged");
    a_cmd_taken:
        assert property (wr && ix == 8'h02 && ok |=> cmd_strobe
            && state_command == $past(pwdata[4:0])) else $error("cmd lost");
    a_cmd_reserved:
        assert property (wr && ix == 8'h02 && !ok && pwdata[4:0] != 5'h00
            |=> !cmd_strobe && $stable(state_command))
        else $error("reserved cmd acted");
    a_tx_symbol:
        assert property (tx_on_air |-> state_command == 5'h02
            && age_r >= SYMBOL_CYC - 3 && age_r <= SYMBOL_CYC)
        else $error("transmit start off time");
    a_retry_fields:
        assert property (wr && ix == 8'h2c |=> frame_retry_limit
            == $past(pwdata[7:4]) && channel_access_retry_limit
            == $past(pwdata[3:1])) else $error("retry fields wrong");
    a_zero_exp:
        assert property (wr && ix == 8'h2e |=> min_backoff_exponent
            == $past(pwdata[7:6]) && cca_immediate
            == ($past(pwdata[7:6]) == 2'h0)) else $error("exponent wrong");
    a_ack_pending:
        assert property (ack_frame_pending |-> ack_for_data_req
            && state_command == 5'h16) else $error("pending set wrongly");
    a_src_filter:
        assert property (frame_src_only && coordinator_flag
            && frame_src_netid != network_id |-> !src_filter_pass)
        else $error("foreign frame passed");
endmodule
bind rsf_regs rsf_checker #(.SYMBOL_CYC(SYMBOL_CYC)) chk_u (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pslverr, .state_command, .cmd_strobe, .tx_on_air, .frame_retry_limit,
    .channel_access_retry_limit, .min_backoff_exponent, .cca_immediate,
    .ack_for_data_req, .ack_frame_pending, .frame_src_only,
    .frame_src_netid, .coordinator_flag, .src_filter_pass, .network_id);
`default_nettype wire

// File: tb_top.sv
// self-checking bench of the radio register bank
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, txa, pass, pend;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic txn_done = 1'b0, ca_exhausted = 1'b0, ack_req = 1'b0;
    logic src_only = 1'b0;
    logic [2:0] res = 3'h0;
    logic [4:0] eng = 5'h00, cmd, st, ec;
    logic [15:0] src_id = 16'h0, sa, ni, lf = 16'h8f57;
    logic [10:0] seed;
    logic [7:0] q;
    int n_mismatch = 0, total_checks = 0, ev[64], k;
    logic [7:0] ixs[7] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h2c, 8'h2d, 8'h2e};
    logic [4:0] cs[8] = '{5'h03, 5'h06, 5'h08, 5'h09, 5'h16, 5'h19, 5'h05,
                          5'h00};
    logic [2:0] rs[5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};
    rsf_mcu m (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
               .prdata, .pready, .pslverr);
    rsf_regs #(.SETTLE_CYC(20), .SYMBOL_CYC(8)) dut_u (
        .pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .txn_done,
        .txn_result(res), .ca_exhausted, .engine_state(eng),
        .ack_for_data_req(ack_req), .frame_src_only(src_only),
        .frame_src_netid(src_id), .state_command(cmd), .cmd_strobe(),
        .tx_on_air(txa), .frame_retry_limit(), .channel_access_retry_limit(),
        .backoff_seed(seed), .min_backoff_exponent(), .cca_immediate(),
        .ack_frame_pending(pend), .coordinator_flag(), .src_filter_pass(pass),
        .short_address(sa), .network_id(ni), .irq);
    initial forever #5 pclk = ~pclk;
    initial begin
        #100us;
        n_mismatch++;
        results();
    end
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // model keeps writable bits only; reserved bits stay zero
    task automatic w(input logic [7:0] ix, input logic [7:0] d);
        m.xfer(1'b1, ix, d, q);
        ev[ix[5:0]] = d & (ix == 8'h2c ? 8'hfe : ix == 8'h2e ? 8'hef : 8'hff);
        // outputs launched by the write edge are settled by the falling edge
        @(negedge pclk);
    endtask
    task automatic rc(input logic [7:0] ix);
        m.xfer(1'b0, ix, 8'h00, q);
        chk(q, ev[ix[5:0]]);
    endtask
    task automatic pulse(input logic ca, input logic [2:0] r);
        @(posedge pclk);
        txn_done <= 1'b1;
        ca_exhausted <= ca;
        res <= r;
        @(posedge pclk);
        txn_done <= 1'b0;
        ca_exhausted <= 1'b0;
    endtask
    initial begin
        ev[45] = 8'hea;
        lf = nx(lf);
        eng <= lf[4:0];
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ixs[i]) rc(ixs[i]);
        foreach (ixs[i]) begin
            lf = nx(lf);
            w(ixs[i], lf[7:0]);
            rc(ixs[i]);
        end
        chk({sa, ni}, {ev[33][7:0], ev[32][7:0], ev[35][7:0], ev[34][7:0]});
        chk(seed, {ev[46][2:0], ev[45][7:0]});
        w(8'h2c, 8'hff);
        rc(8'h2c);
        m.xfer(1'b0, 8'h40, 8'h00, q);
        chk({m.err, q}, 9'h100);
        ec = 5'h00;
        foreach (cs[i]) begin
            m.cmd(cs[i], st);
            if (cs[i] != 5'h05) ec = cs[i];
            chk(cmd, ec);
            chk(st, cs[i] inside {5'h05, 5'h00} ? eng : 5'h1f);
            repeat (24) @(posedge pclk);
        end
        w(8'h02, 8'h02);
        k = 0;
        do begin
            @(posedge pclk);
            #1 k++;
        end while (txa !== 1'b1 && k < 40);
        chk(k inside {[7:9]}, 1'b1);
        m.xfer(1'b0, 8'h01, 8'h00, q);
        chk(q, eng);
        m.xfer(1'b0, 8'h30, 8'h00, q);
        chk(q[1], 1'b1);
        w(8'h31, 8'h00);
        pulse(1'b0, 3'h1);
        chk(irq, 1'b0);
        w(8'h31, 8'h01);
        chk(irq, 1'b1);
        foreach (rs[i]) begin
            w(8'h30, 8'h03);
            chk(irq, 1'b0);
            // failure also carries a bogus result, which it must override
            pulse(rs[i] == 3'h3, rs[i] == 3'h3 ? 3'h5 : rs[i]);
            m.xfer(1'b0, 8'h02, 8'h00, q);
            chk({irq, q[7:5]}, {1'b1, rs[i]});
        end
        w(8'h2e, 8'h28);
        m.cmd(5'h16, st);
        @(posedge pclk);
        src_only <= 1'b1;
        src_id <= ~ni;
        ack_req <= 1'b1;
        @(posedge pclk);
        #1 chk({pend, pass}, 2'b10);
        @(posedge pclk);
        src_id <= ni;
        @(posedge pclk);
        #1 chk(pass, 1'b1);
        w(8'h2e, 8'h08);
        chk(pend, 1'b0);
        results();
    end
endmodule
`default_nettype wire
